// ---- hw/tsp_pkg.sv ----
// Package for the test set path command decoder.
// Holds command addresses, data field layout, register map and reset values.
package tsp_pkg;

   // Command address codes, one per port group plus the DUT line group
   localparam logic [7:0] TSP_ADDR_GRP0 = 8'h00;
   localparam logic [7:0] TSP_ADDR_GRP1 = 8'h10;
   localparam logic [7:0] TSP_ADDR_GRP2 = 8'h20;
   localparam logic [7:0] TSP_ADDR_GRP3 = 8'h40;
   localparam logic [7:0] TSP_ADDR_DUT = 8'h70;

   // Command data field layout
   localparam int TSP_SRC_LSB = 0;
   localparam int TSP_NOISE_BIT = 3;
   localparam int TSP_RCV_LSB = 4;
   localparam int TSP_CODE_W = 2;
   localparam logic [1:0] TSP_CODE_BAD = 2'h3;

   // Alternate column 0 map: 2 bits per group, group 0 in the low bits
   localparam logic [7:0] TSP_ALT_MAP = {2'h1, 2'h3, 2'h2, 2'h0};

   // Register word offsets (byte addresses)
   localparam logic [3:0] TSP_REG_CMD = 4'h0;
   localparam logic [3:0] TSP_REG_CTRL = 4'h4;
   localparam logic [3:0] TSP_REG_STAT = 4'h8;

   // Field positions inside registers
   localparam int TSP_CMD_ADDR_LSB = 0;
   localparam int TSP_CMD_DATA_LSB = 8;
   localparam int TSP_CTRL_ALT = 0;
   localparam int TSP_CTRL_STANDALONE = 1;
   localparam int TSP_STAT_REJ = 0;
   localparam int TSP_STAT_REJ_CNT_LSB = 8;
   localparam int TSP_STAT_ACC_CNT_LSB = 16;

   // Reset values
   localparam logic [1:0] TSP_CTRL_RESET = 2'h2;
   localparam logic [1:0] TSP_COL_RESET = 2'h0;

   // Command kind after address decode
   typedef enum logic [2:0] {
      TSP_K_GRP0 = 3'b000,
      TSP_K_GRP1 = 3'b001,
      TSP_K_GRP2 = 3'b010,
      TSP_K_GRP3 = 3'b011,
      TSP_K_DUT = 3'b100,
      TSP_K_NONE = 3'b111
   } tsp_kind_t;

endpackage : tsp_pkg

// ---- hw/tsp_decoder.sv ----
// Test set path command decoder: Wishbone slave taking address/data
// commands, driving source/receiver switch selects, noise path and DUT lines.
// Assumes one 50 MHz clock, a classic single-cycle Wishbone master on the
// same clock, and switch/line drivers that follow the registered outputs.
`timescale 1ns/100ps

module tsp_decoder
   import tsp_pkg::*;
#(
   parameter int NUM_GROUPS = 4,
   parameter int NUM_PORTS = 12,
   parameter int NUM_LINES = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Switch drivers, one bit per test port
   output logic [NUM_PORTS-1:0] src_path,
   output logic [NUM_PORTS-1:0] rcv_path,
   // Noise source path
   output logic noise_on,
   output logic [1:0] noise_col,
   output logic noise_led,
   // DUT control lines, high means upper rail
   output logic [NUM_LINES-1:0] dut_line
);

   // Decode of an 8-bit command address into its kind
   function automatic tsp_kind_t kind_of(input logic [7:0] a);
      case (a)
         TSP_ADDR_GRP0: kind_of = TSP_K_GRP0;
         TSP_ADDR_GRP1: kind_of = TSP_K_GRP1;
         TSP_ADDR_GRP2: kind_of = TSP_K_GRP2;
         TSP_ADDR_GRP3: kind_of = TSP_K_GRP3;
         TSP_ADDR_DUT: kind_of = TSP_K_DUT;
         default: kind_of = TSP_K_NONE;
      endcase
   endfunction : kind_of

   // Port index for a group and column, honouring the alternate map
   function automatic logic [3:0] port_of(input logic [1:0] g, input logic [1:0] c,
                                          input logic alt);
      logic [1:0] row;
      row = alt && (c == TSP_COL_RESET) ? TSP_ALT_MAP[{g, 1'b0} +: 2] : g;
      port_of = {c, row};
   endfunction : port_of

   // Register state
   logic ack_r;
   logic [31:0] dat_r;
   logic alt_r;
   logic standalone_r;
   logic rej_r;
   logic [7:0] rej_cnt_r;
   logic [15:0] acc_cnt_r;
   logic [1:0] src_col_r [NUM_GROUPS];
   logic [1:0] rcv_col_r [NUM_GROUPS];
   logic noise_on_r;
   logic [1:0] noise_col_r;
   logic [NUM_LINES-1:0] dut_r;
   logic [NUM_PORTS-1:0] src_path_r;
   logic [NUM_PORTS-1:0] rcv_path_r;
   logic [NUM_PORTS-1:0] src_path_nxt;
   logic [NUM_PORTS-1:0] rcv_path_nxt;

   // Bus strobes: a write acts at the edge where the master sees ack
   logic bus_req;
   logic wr_go;
   logic wr_cmd;
   logic wr_ctrl;
   logic wr_stat;
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_go = bus_req & wb_we_i & ack_r;
   assign wr_cmd = wr_go && (wb_adr_i == TSP_REG_CMD) && (wb_sel_i[1:0] == 2'h3);
   assign wr_ctrl = wr_go && (wb_adr_i == TSP_REG_CTRL) && wb_sel_i[0];
   assign wr_stat = wr_go && (wb_adr_i == TSP_REG_STAT) && wb_sel_i[0];

   // Command fields
   logic [7:0] c_addr;
   logic [7:0] c_data;
   logic [1:0] c_src;
   logic [1:0] c_rcv;
   logic c_noise;
   tsp_kind_t c_kind;
   assign c_addr = wb_dat_i[TSP_CMD_ADDR_LSB +: 8];
   assign c_data = wb_dat_i[TSP_CMD_DATA_LSB +: 8];
   assign c_src = c_data[TSP_SRC_LSB +: TSP_CODE_W];
   assign c_rcv = c_data[TSP_RCV_LSB +: TSP_CODE_W];
   assign c_noise = c_data[TSP_NOISE_BIT];
   assign c_kind = kind_of(c_addr);

   // Group data validity; noise only at group 0 with matching columns
   logic grp_ok;
   logic cmd_ok;
   always_comb begin
      grp_ok = (c_src != TSP_CODE_BAD) && (c_rcv != TSP_CODE_BAD) &&
               (c_data[2] == 1'b0) && (c_data[7:6] == 2'h0);
      if (c_noise) begin
         grp_ok = grp_ok && (c_kind == TSP_K_GRP0) && (c_src == c_rcv);
      end
      case (c_kind)
         TSP_K_GRP0, TSP_K_GRP1, TSP_K_GRP2, TSP_K_GRP3: cmd_ok = grp_ok;
         TSP_K_DUT: cmd_ok = 1'b1;
         default: cmd_ok = 1'b0;
      endcase
   end

   // Wishbone answer: ack one cycle after request, dropped the cycle after
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req & ~ack_r;
      end
   end

   // Read data; command word reads zero so no path state leaks out
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dat_r <= 32'h0;
      end else if (bus_req & ~ack_r) begin
         dat_r <= 32'h0;
         case (wb_adr_i)
            TSP_REG_CTRL: begin
               dat_r[TSP_CTRL_ALT] <= alt_r;
               dat_r[TSP_CTRL_STANDALONE] <= standalone_r;
            end
            TSP_REG_STAT: begin
               dat_r[TSP_STAT_REJ] <= rej_r;
               dat_r[TSP_STAT_REJ_CNT_LSB +: 8] <= rej_cnt_r;
               dat_r[TSP_STAT_ACC_CNT_LSB +: 16] <= acc_cnt_r;
            end
            default: dat_r <= 32'h0;
         endcase
      end
   end

   // Control register: map choice and standalone mode
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         alt_r <= TSP_CTRL_RESET[TSP_CTRL_ALT];
         standalone_r <= TSP_CTRL_RESET[TSP_CTRL_STANDALONE];
      end else if (wr_ctrl) begin
         alt_r <= wb_dat_i[TSP_CTRL_ALT];
         standalone_r <= wb_dat_i[TSP_CTRL_STANDALONE];
      end
   end

   // Reject flag: a new reject in the clearing cycle wins over the clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rej_r <= 1'b0;
         rej_cnt_r <= 8'h0;
         acc_cnt_r <= 16'h0;
      end else begin
         if (wr_cmd && !cmd_ok) begin
            rej_r <= 1'b1;
            if (rej_cnt_r != 8'hff) begin
               rej_cnt_r <= rej_cnt_r + 8'h1; // Saturates, never wraps to look clean
            end
         end else if (wr_stat && wb_dat_i[TSP_STAT_REJ]) begin
            rej_r <= 1'b0;
         end
         if (wr_cmd && cmd_ok) begin
            acc_cnt_r <= acc_cnt_r + 16'h1;
         end
      end
   end

   // Per-group column latches; only the addressed group moves
   genvar g;
   generate
      for (g = 0; g < NUM_GROUPS; g++) begin : grp
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               src_col_r[g] <= TSP_COL_RESET;
               rcv_col_r[g] <= TSP_COL_RESET;
            end else if (wr_cmd && cmd_ok && (c_kind == tsp_kind_t'(g))) begin
               src_col_r[g] <= c_src;
               rcv_col_r[g] <= c_rcv;
            end
         end
      end
   endgenerate

   // Noise path: only group 0 commands in standalone mode touch it
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         noise_on_r <= 1'b0;
         noise_col_r <= TSP_COL_RESET;
      end else if (wr_cmd && cmd_ok && (c_kind == TSP_K_GRP0) && standalone_r) begin
         noise_on_r <= c_noise;
         noise_col_r <= c_src;
      end
   end

   // DUT line latches, inverted from the command data; set data bit means lower rail
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dut_r <= '1;
      end else if (wr_cmd && (c_kind == TSP_K_DUT)) begin
         dut_r <= ~c_data[NUM_LINES-1:0];
      end
   end

   // Port select vectors from the group latches
   always_comb begin
      src_path_nxt = '0;
      rcv_path_nxt = '0;
      for (int i = 0; i < NUM_GROUPS; i++) begin
         src_path_nxt[port_of(2'(i), src_col_r[i], alt_r)] = 1'b1;
         rcv_path_nxt[port_of(2'(i), rcv_col_r[i], alt_r)] = 1'b1;
      end
   end

   // Registered switch outputs; one cycle behind the latches, glitch free
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         src_path_r <= '0;
         rcv_path_r <= '0;
      end else begin
         src_path_r <= src_path_nxt;
         rcv_path_r <= rcv_path_nxt;
      end
   end

   // Outputs
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign src_path = src_path_r;
   assign rcv_path = rcv_path_r;
   assign noise_on = noise_on_r;
   assign noise_col = noise_col_r;
   assign noise_led = noise_on_r;
   assign dut_line = dut_r;

endmodule : tsp_decoder

// ---- test/tsp_decoder_sva.sv ----
// Checker for the path command decoder, bound to its top ports.
// Assumes a classic bus master that holds each request until ack.
`timescale 1ns/100ps
module tsp_decoder_sva
   import tsp_pkg::*;
#(parameter int NUM_PORTS = 12, parameter int NUM_LINES = 8) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Outputs
   input wire logic [NUM_PORTS-1:0] src_path,
   input wire logic [NUM_PORTS-1:0] rcv_path,
   input wire logic noise_on,
   input wire logic [1:0] noise_col,
   input wire logic noise_led,
   input wire logic [NUM_LINES-1:0] dut_line
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Command word taken at this edge
   wire cmd_w = wb_ack_o && wb_we_i && wb_adr_i == TSP_REG_CMD && wb_sel_i[1:0] == 2'h3;
   wire known = wb_dat_i[7:0] inside {8'h00, 8'h10, 8'h20, 8'h40, 8'h70};

   ack_late_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   dut_set_a: assert property (cmd_w && wb_dat_i[7:0] == TSP_ADDR_DUT
      |=> dut_line == ~$past(wb_dat_i[15:8])) else $error("dut lines wrong");
   dut_hold_a: assert property (!cmd_w |=> $stable(dut_line))
      else $error("dut lines moved");
   led_track_a: assert property (noise_led == noise_on)
      else $error("led differs");
   led_on_a: assert property ($rose(noise_led) |-> $past(cmd_w && wb_dat_i[7:0] == TSP_ADDR_GRP0
      && wb_dat_i[11])) else $error("led lit without noise command");
   noise_cmd_a: assert property ($changed(noise_on) |-> $past(cmd_w))
      else $error("noise moved alone");
   path_hold_a: assert property (!wb_ack_o && !$past(wb_ack_o) && $past(reset_n)
      |=> $stable(src_path) && $stable(rcv_path)) else $error("paths moved");
   one_col_a: assert property (src_path != '0 |-> $countones(src_path) == 4
      && $countones(rcv_path) == 4) else $error("column count wrong");
   cmd_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == TSP_REG_CMD
      |-> wb_dat_o == '0) else $error("command readback");
   bad_addr_a: assert property (cmd_w && !known |=> $stable(noise_on))
      else $error("unknown address acted");
   // Main scenarios
   cover property (cmd_w && wb_dat_i[7:0] == TSP_ADDR_DUT);
   cover property ($rose(noise_led));
   cover property (cmd_w && !known);
endmodule : tsp_decoder_sva

bind tsp_decoder tsp_decoder_sva #(.NUM_PORTS(NUM_PORTS), .NUM_LINES(NUM_LINES))
   tsp_decoder_sva_inst (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_path(src_path),
   .rcv_path(rcv_path), .noise_on(noise_on), .noise_col(noise_col),
   .noise_led(noise_led), .dut_line(dut_line));

// ---- test/tsp_host.sv ----
// Host model: classic single-cycle bus master sending decoder commands.
// Assumes the decoder acks every request, mapped or not.
`timescale 1ns/100ps
module tsp_host (
   // Clock
   input wire logic clock,
   // Request
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [3:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat,
   // Answer
   input wire logic ack,
   input wire logic [31:0] rdat
);
   initial {cyc, stb, we, adr, sel, dat} = '0;
   // A command word packs address low, data above it
   task xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, 4'hf, d};
      do @(posedge clock); while (ack !== 1'b1);
      q = rdat;
      // Released lines are scrambled so no one leans on stale values
      {cyc, stb, adr, dat} <= {2'h0, ~a, ~d};
      @(posedge clock);
   endtask : xfer
endmodule : tsp_host

// ---- test/test_set_path_command_decoder_test.sv ----
// Self-checking bench for the path command decoder against a reference model.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module test_set_path_command_decoder_test;
   import tsp_pkg::*;
   // Stimulus and wires
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   wire cyc, stb, we, ack, noise_on, noise_led;
   wire [3:0] adr, sel;
   wire [31:0] dat, rdat;
   wire [11:0] src_path, rcv_path;
   wire [1:0] noise_col;
   wire [7:0] dut_line;
   int failures = 0;
   int samples_checked = 0;
   // Reference state
   int src_m[4], rcv_m[4], g;
   int alt_p[4] = '{0, 2, 3, 1};
   logic alt_m = 1'b0, sa_m = 1'b1, noise_m = 1'b0;
   logic [1:0] col_m;
   logic [7:0] dut_m = 8'hff;
   // Accepted and refused command counts, mirrored from the status word
   int acc_m = 0, rej_m = 0;
   logic [7:0] grp_a[4] = '{8'h00, 8'h10, 8'h20, 8'h40};
   logic [7:0] nz_d[5] = '{8'h08, 8'h19, 8'h2a, 8'h00, 8'h2a};
   logic [31:0] q, w_m;

   always #10 clock = ~clock;

   tsp_host tsp_host_inst (.clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
      .sel(sel), .dat(dat), .ack(ack), .rdat(rdat));
   tsp_decoder tsp_decoder_inst (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .src_path(src_path), .rcv_path(rcv_path),
      .noise_on(noise_on), .noise_col(noise_col), .noise_led(noise_led),
      .dut_line(dut_line));

   // Expected one-hot port pattern for the group columns
   function automatic logic [11:0] path(input int c[4]);
      logic [11:0] r;
      r = '0;
      for (int k = 0; k < 4; k++) r[(c[k] == 0 && alt_m) ? alt_p[k] : k + 4 * c[k]] = 1'b1;
      return r;
   endfunction : path

   task close_out;
      if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   // Paths lag the latches by one edge, so look at the falling edge after
   task chk;
      @(negedge clock);
      `CHK(src_path, path(src_m))
      `CHK(rcv_path, path(rcv_m))
      `CHK(dut_line, dut_m)
      `CHK(noise_led, noise_m)
      `CHK(noise_on, noise_m)
      if (noise_m) `CHK(noise_col, col_m)
   endtask : chk

   task ctrl(input logic al, input logic s);
      tsp_host_inst.xfer(1'b1, TSP_REG_CTRL, {30'h0, s, al}, q);
      {alt_m, sa_m} = {al, s};
      chk();
   endtask : ctrl

   // Malformed data is refused whole; noise only at group 0 with equal columns
   task cmd(input logic [7:0] ca, input logic [7:0] cd);
      tsp_host_inst.xfer(1'b1, TSP_REG_CMD, {16'h0, cd, ca}, q);
      if (ca == TSP_ADDR_DUT) begin
         dut_m = ~cd;
         acc_m++;
      end else if (ca inside {8'h00, 8'h10, 8'h20, 8'h40} && cd[7:6] == 2'h0 && !cd[2]
         && cd[1:0] != 2'h3 && cd[5:4] != 2'h3 && (!cd[3] || (ca == 8'h00
         && cd[1:0] == cd[5:4]))) begin
         g = (ca == 8'h40) ? 3 : ca[5:4];
         {src_m[g], rcv_m[g]} = {30'h0, cd[1:0], 30'h0, cd[5:4]};
         if (ca == 8'h00 && sa_m) {noise_m, col_m} = {cd[3], cd[1:0]};
         acc_m++;
      end else begin
         rej_m++;
      end
      chk();
   endtask : cmd

   initial begin
      void'($urandom(48630));
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      chk();
      // Random groups, each written by its own command
      for (int i = 0; i < 200; i++) begin
         if (i % 40 == 0) ctrl(i % 80 == 0, 1'b1);
         cmd(grp_a[$urandom % 4], 8'($urandom % 3) + 8'h10 * 8'($urandom % 3));
      end
      foreach (nz_d[k]) cmd(8'h00, nz_d[k]);
      ctrl(1'b0, 1'b0);
      cmd(8'h00, 8'h08);
      ctrl(1'b0, 1'b1);
      cmd(TSP_ADDR_DUT, 8'h00);
      cmd(TSP_ADDR_DUT, 8'hff);
      repeat (20) cmd(TSP_ADDR_DUT, 8'($urandom));
      cmd(8'h30, 8'h11);
      cmd(8'h10, 8'h03);
      cmd(8'h40, 8'h34);
      cmd(8'h20, 8'h48);
      tsp_host_inst.xfer(1'b0, TSP_REG_CMD, 32'h0, q);
      `CHK(q, 32'h0)
      tsp_host_inst.xfer(1'b0, 4'hc, 32'h0, q);
      `CHK(q, 32'h0)
      // Status counts every command; the sticky reject bit clears on a write of one
      w_m = {16'(acc_m), 8'(rej_m), 7'h0, rej_m != 0};
      tsp_host_inst.xfer(1'b0, TSP_REG_STAT, 32'h0, q);
      `CHK(q, w_m)
      tsp_host_inst.xfer(1'b1, TSP_REG_STAT, 32'h1, q);
      w_m = {16'(acc_m), 8'(rej_m), 8'h0};
      tsp_host_inst.xfer(1'b0, TSP_REG_STAT, 32'h0, q);
      `CHK(q, w_m)
      w_m = {30'h0, sa_m, alt_m};
      tsp_host_inst.xfer(1'b0, TSP_REG_CTRL, 32'h0, q);
      `CHK(q, w_m)
      close_out();
   end

   // Watchdog far beyond the thousand or so cycles the run needs
   initial begin
      #400000;
      failures++;
      close_out();
   end
endmodule : test_set_path_command_decoder_test
